// ==== lcd_port_pkg.sv ====
// constants, field layouts and carrier types of the lcd driver write port
// assumes one 50 MHz system clock; the oscillator arrives as a sampled pin
package lcd_port_pkg;

   // ---------------------------------------------------------------
   // clock and processing time, in oscillator clocks
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] PROC_DISPLAY_CLOCKS = 4'hA; // inside 9.5 .. 10.5
   localparam logic [3:0] PROC_OTHER_CLOCKS = 4'h3;   // inside 2.5 .. 3.5

   // ---------------------------------------------------------------
   // command layout, first byte (or first two nibbles) forms byte0, the rest byte1
   // ---------------------------------------------------------------
   localparam int TYPE_LO = 6;                // kind field, bits 7:6 of byte0
   localparam logic [1:0] TYPE_DISPLAY = 2'h0;
   localparam logic [1:0] TYPE_BIT = 2'h1;
   localparam logic [1:0] TYPE_MODE = 2'h2;
   localparam logic [1:0] TYPE_SKIP = 2'h3;   // one-item instruction
   localparam int ADDR_W = 6;                 // digit or segment address
   localparam int BIT_VALUE_POS = 7;          // bit value inside byte1
   localparam int COM_LO = 0;                 // common address, byte1 1:0
   localparam int MODE_DISP_LO = 6;
   localparam int MODE_DRIVE_LO = 4;
   localparam int MODE_OFF_POS = 1;
   localparam int MODE_READY_POS = 0;

   // ---------------------------------------------------------------
   // drive mode encoding and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] DRIVE_STATIC = 2'h0;
   localparam logic [1:0] DRIVE_HALF = 2'h1;
   localparam logic [1:0] DRIVE_THIRD = 2'h2;
   localparam logic [1:0] DRIVE_QUARTER = 2'h3;
   localparam logic RST_LCD_OFF = 1'h1;
   localparam logic RST_READY_FREE = 1'h0;
   localparam logic [1:0] RST_DRIVE = 2'h0;

   typedef enum logic [1:0] {KIND_DISPLAY, KIND_BIT, KIND_MODE} cmd_kind_t;

   // assembled command on its way to the executor
   typedef struct packed {
      cmd_kind_t kind;
      logic [7:0] byte0;
      logic [7:0] byte1;
   } cmd_t;

   // write towards the display memory
   typedef struct packed {
      logic bit_op;       // 1: single bit, 0: whole digit pattern
      logic [7:0] addr;   // digit address, or {common, segment}
      logic [7:0] data;   // pattern, or value in bit 0
   } ram_wr_t;

endpackage

// ==== cmd_skid_buffer.sv ====
// two-entry valid/ready buffer for assembled commands
// assumes both sides on the same clock; the drain side may stall freely
`timescale 1ns/1ns
module cmd_skid_buffer #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 2
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);

   // ---------------------------------------------------------------
   // storage and pointers
   // ---------------------------------------------------------------
   initial begin
      if (DEPTH != 2 || WIDTH < 1) begin
         $error("cmd_skid_buffer: only two entries of nonzero width");
      end
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;

   // full and empty come straight from the occupancy count
   assign in_ready_o = (count_r != 2'h2);
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // entry storage has no reset, it is only read while counted valid
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // pointers and count
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= 1'h0;
         rd_ptr_r <= 1'h0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= !wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= !rd_ptr_r;
         end
         count_r <= count_r + {1'h0, push} - {1'h0, pop};
      end
   end

endmodule

// ==== lcd_write_port.sv ====
// write-only host port of a segment lcd driver: framing, mode latch, ready
// assumes the host pins and the oscillator pin are asynchronous to clock_i
//
// Contract
// - 4-bit bit command writes one addressed bit
// - blanking bit 1 is off; sync sets it
// - gated ready low only with select and clear
// - free ready low whenever processing
// - 4-bit first nibble 11 is skipped
// - 8-bit commands are two counted bytes
// - select plus clear low resets the count
// - 8-bit resync by repeated skip bytes
// - 4-bit commands are four counted nibbles
// - 4-bit resync by repeated skip nibbles
// - static RAM style select, strobe, data
// - ready unsettled briefly after first mode write
// - sync gives ready mode a defined value
// - standby stops drive and oscillator
// - standby keeps memory and mode settings
// - standby suspends processing, resumes after release
// - sync holds drive timing in reset
// - ready low while processing, writes refused; gated ready stays high without select and clear
// - bit and mode processing three clocks
// - drive field 00 static to 11 quarter
`timescale 1ns/1ns
module lcd_write_port #(
   parameter bit NIBBLE_PORT = 1'b0   // 0: two bytes, 1: four nibbles
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic we_b_i,
   input wire logic sequence_clear_low_b_i,
   input wire logic [7:0] data_i,
   input wire logic standby_request_i,
   input wire logic sync_i,
   input wire logic osc_clock_input_i,
   input wire logic ram_ready_i,
   output logic ready_o,
   output logic lcd_off_o,
   output logic lcd_drive_en_o,
   output logic osc_run_o,
   output logic timing_reset_o,
   output logic ready_free_o,
   output logic [1:0] drive_mode_o,
   output logic [1:0] display_mode_o,
   output logic [2:0] commons_o,
   output logic [1:0] sequence_pos_o,
   output logic ram_wr_valid_o,
   output lcd_port_pkg::ram_wr_t ram_wr_o
);
   import lcd_port_pkg::*;

   initial begin
      if (NIBBLE_PORT !== 1'b0 && NIBBLE_PORT !== 1'b1) begin
         $error("lcd_write_port: NIBBLE_PORT must be 0 or 1");
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // number of common lines for a drive mode code
   function automatic logic [2:0] duty_commons(input logic [1:0] mode);
      case (mode)
         DRIVE_STATIC: duty_commons = 3'h1;
         DRIVE_HALF: duty_commons = 3'h2;
         DRIVE_THIRD: duty_commons = 3'h3;
         DRIVE_QUARTER: duty_commons = 3'h4;
         default: duty_commons = 3'h1;
      endcase
   endfunction

   // kind field of an incoming item, taken from its top two bits
   function automatic logic [1:0] item_type(input logic [7:0] d);
      item_type = NIBBLE_PORT ? d[3:2] : d[7:6];
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   localparam int PIN_W = 14;
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s1;
   logic [PIN_W-1:0] pins_s2;
   localparam logic [PIN_W-1:0] PINS_IDLE = 14'h3800; // select, strobe and clear high

   assign pins_raw = {cs_b_i, we_b_i, sequence_clear_low_b_i, standby_request_i,
                      sync_i, osc_clock_input_i, data_i};

   // two stages on every pin; only the second stage is ever looked at
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         pins_s1 <= PINS_IDLE;
         pins_s2 <= PINS_IDLE;
      end else begin
         pins_s1 <= pins_raw;
         pins_s2 <= pins_s1;
      end
   end

   logic cs_b_s;
   logic we_b_s;
   logic clr_b_s;
   logic standby_s;
   logic sync_s;
   logic osc_s;
   logic [7:0] data_s;
   assign {cs_b_s, we_b_s, clr_b_s, standby_s, sync_s, osc_s, data_s} = pins_s2;

   // ---------------------------------------------------------------
   // edge detection of strobe and oscillator
   // ---------------------------------------------------------------
   logic we_b_prev_r;
   logic osc_prev_r;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         we_b_prev_r <= 1'h1;
         osc_prev_r <= 1'h0;
      end else begin
         we_b_prev_r <= we_b_s;
         osc_prev_r <= osc_s;
      end
   end

   logic we_rise;
   logic osc_tick;
   logic seq_clear;
   // data is latched on the rising strobe edge while selected
   assign we_rise = we_b_s && !we_b_prev_r && !cs_b_s;
   // a halted oscillator gives no ticks, so processing freezes
   assign osc_tick = osc_s && !osc_prev_r && !standby_s;
   assign seq_clear = !cs_b_s && !clr_b_s;

   // ---------------------------------------------------------------
   // sequence counter and item assembly
   // ---------------------------------------------------------------
   logic busy;
   logic take;
   logic last_item;
   logic skip_item;
   logic [1:0] pos_r;
   logic [1:0] pos_nxt;
   logic [15:0] asm_r;
   logic [15:0] asm_nxt;
   logic [1:0] last_pos;
   logic push_valid;
   logic buf_in_ready;
   cmd_t push_cmd;

   assign last_pos = NIBBLE_PORT ? 2'h3 : 2'h1;
   // busy or standby strobes are dropped without touching the count
   assign take = we_rise && !busy && !standby_s && !seq_clear;
   // a leading skip item leaves the count at the first position
   assign skip_item = (pos_r == 2'h0) && (item_type(data_s) == TYPE_SKIP);
   assign last_item = (pos_r == last_pos);
   // only the count tells the items apart
   assign asm_nxt = NIBBLE_PORT ? {asm_r[11:0], data_s[3:0]} : {asm_r[7:0], data_s};

   // next count: clear wins, then a counted item moves it on
   always_comb begin
      pos_nxt = pos_r;
      if (seq_clear) begin
         pos_nxt = 2'h0; // display data untouched
      end else if (take && !skip_item) begin
         pos_nxt = last_item ? 2'h0 : pos_r + 2'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         pos_r <= 2'h0;
      end else begin
         pos_r <= pos_nxt;
      end
   end

   // item shift register; a command is always sixteen bits wide
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         asm_r <= 16'h0000;
      end else if (take && !skip_item) begin
         asm_r <= asm_nxt;
      end
   end

   // complete command goes straight into the buffer
   always_comb begin
      push_cmd.byte0 = asm_nxt[15:8];
      push_cmd.byte1 = asm_nxt[7:0];
      case (asm_nxt[8+TYPE_LO+:2])
         TYPE_DISPLAY: push_cmd.kind = KIND_DISPLAY;
         TYPE_BIT: push_cmd.kind = KIND_BIT;
         default: push_cmd.kind = KIND_MODE;
      endcase
   end
   assign push_valid = take && !skip_item && last_item;

   // ---------------------------------------------------------------
   // command buffer
   // ---------------------------------------------------------------
   localparam int CMD_W = $bits(cmd_t);
   logic buf_out_valid;
   logic buf_out_ready;
   cmd_t buf_out_data;

   cmd_skid_buffer #(
      .WIDTH(CMD_W),
      .DEPTH(2)
   ) u_cmd_buf (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .in_data_i(push_cmd),
      .in_valid_i(push_valid),
      .in_ready_o(buf_in_ready),
      .out_data_o(buf_out_data),
      .out_valid_o(buf_out_valid),
      .out_ready_i(buf_out_ready)
   );

   // ---------------------------------------------------------------
   // executor: timed processing, then memory write or mode load
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {EX_IDLE, EX_PROC, EX_STORE} ex_state_t;
   ex_state_t ex_state_r;
   cmd_t cur_r;
   logic [3:0] ticks_r;
   logic mode_load;
   logic proc_done;

   assign buf_out_ready = (ex_state_r == EX_IDLE);
   assign proc_done = (ex_state_r == EX_PROC) && osc_tick && (ticks_r == 4'h1);
   assign mode_load = proc_done && (cur_r.kind == KIND_MODE);
   // full buffer also counts as busy, so back-pressure reaches the host
   assign busy = buf_out_valid || (ex_state_r != EX_IDLE) || !buf_in_ready;

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         ex_state_r <= EX_IDLE;
         cur_r <= '0;
         ticks_r <= 4'h0;
      end else begin
         case (ex_state_r)
            EX_IDLE: begin
               if (buf_out_valid) begin
                  cur_r <= buf_out_data;
                  // digit writes take longer than bit and mode commands
                  ticks_r <= (buf_out_data.kind == KIND_DISPLAY) ?
                             PROC_DISPLAY_CLOCKS : PROC_OTHER_CLOCKS;
                  ex_state_r <= EX_PROC;
               end
            end
            EX_PROC: begin
               if (osc_tick) begin
                  ticks_r <= ticks_r - 4'h1;
               end
               if (proc_done) begin
                  ex_state_r <= (cur_r.kind == KIND_MODE) ? EX_IDLE : EX_STORE;
               end
            end
            EX_STORE: begin
               // memory writes are held off during standby
               if (ram_ready_i && !standby_s) begin
                  ex_state_r <= EX_IDLE;
               end
            end
            default: ex_state_r <= EX_IDLE;
         endcase
      end
   end

   // memory write: digit pattern, or a single bit at its segment
   always_comb begin
      ram_wr_o.bit_op = (cur_r.kind == KIND_BIT);
      ram_wr_o.data = cur_r.byte1;
      ram_wr_o.addr = {2'h0, cur_r.byte0[ADDR_W-1:0]};
      if (cur_r.kind == KIND_BIT) begin
         ram_wr_o.data = {7'h00, cur_r.byte1[BIT_VALUE_POS]};
         // the nibble port has no common address
         ram_wr_o.addr = {NIBBLE_PORT ? 2'h0 : cur_r.byte1[COM_LO+:2],
                          cur_r.byte0[ADDR_W-1:0]};
      end
   end
   assign ram_wr_valid_o = (ex_state_r == EX_STORE) && !standby_s;

   // ---------------------------------------------------------------
   // mode latch
   // ---------------------------------------------------------------
   logic lcd_off_r;
   logic ready_free_r;
   logic [1:0] drive_mode_r;
   logic [1:0] display_mode_r;

   // sync wins over a mode load; reset values keep ready defined
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         lcd_off_r <= RST_LCD_OFF;
         ready_free_r <= RST_READY_FREE;
         drive_mode_r <= RST_DRIVE;
         display_mode_r <= RST_DRIVE;
      end else if (sync_s) begin
         lcd_off_r <= 1'h1;
         ready_free_r <= 1'h0;
      end else if (mode_load) begin
         lcd_off_r <= cur_r.byte1[MODE_OFF_POS];
         ready_free_r <= cur_r.byte1[MODE_READY_POS];
         // the nibble port only carries the two flag bits
         if (!NIBBLE_PORT) begin
            drive_mode_r <= cur_r.byte1[MODE_DRIVE_LO+:2];
            display_mode_r <= cur_r.byte1[MODE_DISP_LO+:2];
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // gated mode pulls ready low only under select and clear
   assign ready_o = !(busy && (ready_free_r || seq_clear));
   assign lcd_off_o = lcd_off_r;
   assign lcd_drive_en_o = !lcd_off_r && !standby_s;
   assign osc_run_o = !standby_s;
   assign timing_reset_o = sync_s;
   assign ready_free_o = ready_free_r;
   assign drive_mode_o = drive_mode_r;
   assign display_mode_o = display_mode_r;
   assign commons_o = duty_commons(drive_mode_r);
   assign sequence_pos_o = pos_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   logic [3:0] seen_ticks_r;
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || ex_state_r != EX_PROC) begin
         seen_ticks_r <= 4'h0;
      end else if (osc_tick) begin
         seen_ticks_r <= seen_ticks_r + 4'h1;
      end
   end

   sequence s_cmd_done;
      push_valid;
   endsequence
   sequence s_busy_hold;
      busy [*2];
   endsequence

   a_done_busy: assert property (s_cmd_done |=> s_busy_hold)
      else $error("busy did not follow a complete command");
   a_clear_count: assert property (seq_clear |=> pos_r == 2'h0)
      else $error("select plus clear did not reset the count");
   a_busy_ignored: assert property (we_rise && busy && !seq_clear |=> $stable(pos_r))
      else $error("write during busy moved the count");
   a_skip_item: assert property (take && skip_item |=> pos_r == 2'h0 && !buf_out_valid)
      else $error("skip item was counted");
   a_gated_ready: assert property (!ready_free_r && !seq_clear |-> ready_o)
      else $error("gated ready low without select and clear");
   a_free_ready: assert property (ready_free_r && busy |-> !ready_o)
      else $error("free ready high while processing");
   a_sync_mode: assert property (sync_s |=> lcd_off_r && !ready_free_r)
      else $error("sync did not force mode bits");
   a_proc_time: assert property (proc_done |-> seen_ticks_r + 4'h1 ==
      ((cur_r.kind == KIND_DISPLAY) ? PROC_DISPLAY_CLOCKS : PROC_OTHER_CLOCKS))
      else $error("processing time wrong");
   a_standby_hold: assert property (standby_s && !sync_s |-> !ram_wr_valid_o ##1
      $stable({lcd_off_r, ready_free_r, drive_mode_r, display_mode_r}))
      else $error("standby changed mode or memory");
   a_standby_off: assert property (standby_s |-> !lcd_drive_en_o && !osc_run_o)
      else $error("standby left drive running");

endmodule

// ==== host_model.sv ====
// host side model: a processor writing commands with static ram cycles
// assumes clock_i is the system clock; all pins change 1 ns after its rise
`timescale 1ns/1ns
module host_model (
   input wire logic clock_i,
   output logic cs_b_o,
   output logic we_b_o,
   output logic clr_b_o,
   output logic [7:0] data_o
);
   // ---------------------------------------------------------------
   // idle pins and strobe cycles
   // ---------------------------------------------------------------
   initial begin
      cs_b_o = 1'b1;
      we_b_o = 1'b1;
      clr_b_o = 1'b1;
      data_o = 8'h00;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   // select, data and strobe held well past the rise that latches the data
   task automatic write_item(input logic [7:0] d);
      step(1);
      cs_b_o = 1'b0;
      data_o = d;
      we_b_o = 1'b0;
      step(4);
      we_b_o = 1'b1;
      step(4);
      cs_b_o = 1'b1;
      data_o = ~d; // a released bus never shows the last value
   endtask

   // both items back to back, never interrupted
   task automatic command(input logic [7:0] b0, input logic [7:0] b1);
      write_item(b0);
      write_item(b1);
   endtask

   // select and counter clear driven together
   task automatic sel_clear(input logic on);
      step(1);
      cs_b_o = ~on;
      clr_b_o = ~on;
   endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench of the lcd write port, byte variant
// assumes host_model drives the pins; ram side stalls at random
`timescale 1ns/1ns
module tb_top;
   import lcd_port_pkg::*;
   localparam int OP_BIT = 180; // 4.5 osc clocks of 40 cycles, covering processing plus pin delay
   logic clock_i, rst_b_i, cs_b, we_b, clr_b, standby, sync, osc, ram_ready;
   logic [7:0] data;
   logic ready_o, lcd_off_o, drive_en_o, osc_run_o, treset_o, rfree_o, wr_valid_o;
   logic [1:0] drive_o, disp_o, pos_o;
   logic [2:0] commons_o;
   ram_wr_t wr_o;
   ram_wr_t notes[$];
   int err_count, num_checks;

   lcd_write_port #(.NIBBLE_PORT(1'b0)) dut (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .cs_b_i(cs_b),
      .we_b_i(we_b),
      .sequence_clear_low_b_i(clr_b),
      .data_i(data),
      .standby_request_i(standby),
      .sync_i(sync),
      .osc_clock_input_i(osc),
      .ram_ready_i(ram_ready),
      .ready_o(ready_o),
      .lcd_off_o(lcd_off_o),
      .lcd_drive_en_o(drive_en_o),
      .osc_run_o(osc_run_o),
      .timing_reset_o(treset_o),
      .ready_free_o(rfree_o),
      .drive_mode_o(drive_o),
      .display_mode_o(disp_o),
      .commons_o(commons_o),
      .sequence_pos_o(pos_o),
      .ram_wr_valid_o(wr_valid_o),
      .ram_wr_o(wr_o)
   );
   host_model host (
      .clock_i(clock_i),
      .cs_b_o(cs_b),
      .we_b_o(we_b),
      .clr_b_o(clr_b),
      .data_o(data)
   );

   // ---------------------------------------------------------------
   // clocks, random ram stalls and watchdog
   // ---------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   initial begin
      osc = 1'b0;
      forever #400 osc = ~osc;
   end
   // stalls make every memory write wait a random number of cycles
   initial begin
      ram_ready = 1'b0;
      forever begin
         @(posedge clock_i);
         #1;
         ram_ready = ($urandom % 4) != 0;
      end
   end
   initial begin
      #(20000 * 20);
      err_count++;
      close_out();
   end

   // ---------------------------------------------------------------
   // compare tasks and verdict
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // every field of the memory write is held against the oldest note
   task automatic chk_wr(input ram_wr_t got);
      ram_wr_t exp;
      exp = (notes.size() > 0) ? notes.pop_front() : 17'h1FFFF;
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error ram_wr expected %h seen %h", exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // monitor: each accepted memory write takes the oldest note
   always @(posedge clock_i) begin
      if (rst_b_i === 1'b1 && wr_valid_o === 1'b1 && ram_ready === 1'b1) begin
         chk_wr(wr_o);
      end
   end

   // ---------------------------------------------------------------
   // command helpers
   // ---------------------------------------------------------------
   task automatic wait_ready(input int n);
      int k;
      k = 0;
      while (ready_o !== 1'b1 && k < n) begin
         host.step(1);
         k++;
      end
      chk("ready", 8'h01, 8'(ready_o));
   endtask

   task automatic mode(input logic [1:0] drv, input logic off, input logic rdy);
      host.command({TYPE_MODE, 6'h00}, {drv, drv, 2'h0, off, rdy});
   endtask

   task automatic disp(input logic [5:0] a, input logic [7:0] d);
      notes.push_back('{1'b0, {2'h0, a}, d});
      host.command({TYPE_DISPLAY, a}, d);
   endtask

   task automatic bitc(input logic [5:0] s, input logic [1:0] c, input logic v);
      notes.push_back('{1'b1, {c, s}, {7'h00, v}});
      host.command({TYPE_BIT, s}, {v, 5'h00, c});
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      err_count = 0;
      num_checks = 0;
      rst_b_i = 1'b0;
      standby = 1'b0;
      sync = 1'b0;
      void'($urandom(52));
      repeat (3) @(posedge clock_i);
      #1;
      rst_b_i = 1'b1;
      host.step(3);
      chk("ready", 8'h01, 8'(ready_o));
      chk("ready_free", 8'h00, 8'(rfree_o));
      chk("lcd_off", 8'h01, 8'(lcd_off_o));
      // first mode in gated mode, ready gives no sign, so wait the bound
      mode(2'h0, 1'b0, 1'b1);
      host.step(OP_BIT);
      for (int i = 0; i < 4; i++) begin
         mode(2'(i), 1'b0, 1'b1);
         chk("ready", 8'h00, 8'(ready_o));
         host.step(70);
         chk("ready", 8'h00, 8'(ready_o));
         wait_ready(110);
         chk("drive", 8'(i), 8'(drive_o));
         chk("disp_mode", 8'(i), 8'(disp_o));
         chk("commons", 8'(i + 1), 8'(commons_o));
         chk("lcd_off", 8'h00, 8'(lcd_off_o));
      end
      // random display and bit commands, each display command followed by a refused strobe
      for (int i = 0; i < 3; i++) begin
         disp(6'($urandom), 8'($urandom));
         host.write_item(8'h5A);
         chk("pos", 8'h00, 8'(pos_o));
         wait_ready(1500);
         bitc(6'($urandom), 2'($urandom), 1'($urandom));
         wait_ready(400);
      end
      // broken transfer recovered by clear, then by skip bytes
      host.write_item({TYPE_DISPLAY, 6'h01});
      chk("pos", 8'h01, 8'(pos_o));
      host.sel_clear(1'b1);
      host.step(4);
      host.sel_clear(1'b0);
      chk("pos", 8'h00, 8'(pos_o));
      host.write_item({TYPE_DISPLAY, 6'h02});
      // the first skip byte completes the cut command, so the display changes
      notes.push_back('{1'b0, 8'h02, 8'hC0});
      host.write_item(8'hC0);
      chk("pos", 8'h00, 8'(pos_o));
      wait_ready(1500);
      host.write_item(8'hC0);
      chk("pos", 8'h00, 8'(pos_o));
      disp(6'h2A, 8'hA5);
      wait_ready(1500);
      // gated ready: low only with select and clear both low
      mode(2'h3, 1'b0, 1'b0);
      wait_ready(200);
      chk("ready_free", 8'h00, 8'(rfree_o));
      bitc(6'h3F, 2'h3, 1'b1);
      host.step(5);
      chk("ready", 8'h01, 8'(ready_o));
      host.sel_clear(1'b1);
      host.step(4);
      chk("ready", 8'h00, 8'(ready_o));
      host.sel_clear(1'b0);
      host.step(4);
      chk("ready", 8'h01, 8'(ready_o));
      host.step(OP_BIT + 200);
      // sync forces blanking and gated ready, then the mode is rewritten
      mode(2'h1, 1'b0, 1'b1);
      host.step(OP_BIT);
      sync = 1'b1;
      host.step(4);
      chk("lcd_off", 8'h01, 8'(lcd_off_o));
      chk("ready_free", 8'h00, 8'(rfree_o));
      chk("timing_reset", 8'h01, 8'(treset_o));
      sync = 1'b0;
      host.step(4);
      chk("timing_reset", 8'h00, 8'(treset_o));
      mode(2'h1, 1'b0, 1'b1);
      host.step(OP_BIT);
      // standby in mid-processing suspends it and keeps the settings
      disp(6'h15, 8'h3C);
      host.step(20);
      standby = 1'b1;
      host.step(4);
      chk("osc_run", 8'h00, 8'(osc_run_o));
      chk("drive_en", 8'h00, 8'(drive_en_o));
      host.step(1000);
      chk("ready", 8'h00, 8'(ready_o));
      chk("drive", 8'h01, 8'(drive_o));
      chk("ready_free", 8'h01, 8'(rfree_o));
      standby = 1'b0;
      wait_ready(700);
      sync = 1'b1;
      host.step(4);
      sync = 1'b0;
      host.step(4);
      mode(2'h1, 1'b0, 1'b1);
      host.step(OP_BIT);
      chk("drive_en", 8'h01, 8'(drive_en_o));
      chk("notes_left", 8'h00, 8'(notes.size()));
      close_out();
   end
endmodule
